//--- sac_cfg.svh
// constants for the converter control block: offsets, reset values, timing
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

// ----------------------------------------------------------------------
// register indices on the plain register port
// ----------------------------------------------------------------------
`define SAC_ADDR_W           3
`define SAC_OFS_CTRL0        3'h0
`define SAC_OFS_PIN_CONFIG   3'h1
`define SAC_OFS_TIMING       3'h2
`define SAC_OFS_RESULT_HIGH  3'h3
`define SAC_OFS_RESULT_LOW   3'h4
`define SAC_OFS_STATUS       3'h5

// ----------------------------------------------------------------------
// reset values and implemented-bit masks
// ----------------------------------------------------------------------
`define SAC_CTRL0_RESET      8'h00
`define SAC_PIN_RESET        8'h0f
`define SAC_TIMING_RESET     8'h00
`define SAC_CTRL0_MASK       8'h8f
`define SAC_PIN_MASK         8'h1f
`define SAC_TIMING_MASK      8'hbf
`define SAC_PIN3_BIT         3
`define SAC_STATUS_FLAG_BIT  0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SAC_CLK_MHZ          125
`define SAC_TCY_NS           32
`define SAC_TCY_CYCLES       ((`SAC_TCY_NS * `SAC_CLK_MHZ) / 1000)
`define SAC_CONV_TADS        11
`define SAC_WAIT_TADS        2
`define SAC_RC_CODE_LOW      2'h3

`endif

//--- sac_pkg.sv
// types shared by the converter control block
package sac_pkg;

  typedef enum logic [2:0] {
    ST_SAMPLE,
    ST_RC_DELAY,
    ST_ACQUIRE,
    ST_CONVERT,
    ST_WAIT
  } sac_state_t;

  typedef struct packed {
    logic       pwm_trigger_enable;
    logic [2:0] unused;
    logic [1:0] channel_select;
    logic       go;
    logic       converter_on;
  } sac_ctrl0_t;

  typedef struct packed {
    logic [2:0] unused;
    logic       reference_select;
    logic [3:0] pin_analog_select;
  } sac_pin_config_t;

  typedef struct packed {
    logic       result_justify;
    logic       unused;
    logic [2:0] acquisition_time_select;
    logic [2:0] conversion_clock_select;
  } sac_timing_t;

  typedef struct packed {
    logic       converter_on;
    logic [1:0] channel_select;
    logic       reference_select;
    logic       sample_switch_closed;
    logic [9:0] dac_code;
    logic [3:0] pin_analog;
  } sac_analog_t;

endpackage : sac_pkg

//--- sac_adc_ctrl.sv
// control logic of a four-channel 10-bit successive-approximation converter
//
// Contract
// - channel code 0..3 picks analog input 0..3
// - go bit reads 1 while converting, else 0
// - converter_on powers module, resets to 0
// - enabled pwm trigger sets go and converts
// - result_justify 1 right, 0 left justified
// - acquisition code sets 0..20 bit periods
// - clock code picks divider or internal RC
// - RC clock starts one instruction cycle late
// - reference_select picks external reference or supply
// - pin bits 1 analog, reset to 1
// - pin3 bit reads 0 without digital function
// - unimplemented control bits read as 0
// - reset restores control registers, aborts conversion, powers off
// - completion loads result, clears go, flags
// - result pair untouched by reset
// - two bit periods wait after conversion ends
// - programmed acquisition precedes conversion start
// - sampling switch opens when conversion starts
// - clearing go aborts, keeps old result
// - conversion lasts eleven bit periods
`timescale 1ns/1ps
`default_nettype none
`include "sac_cfg.svh"

module sac_adc_ctrl
  import sac_pkg::*;
(
  input  wire logic                   ref_clk_in,
  input  wire logic                   rst_in,
  input  wire logic [`SAC_ADDR_W-1:0] reg_addr_in,
  input  wire logic [7:0]             reg_wdata_in,
  input  wire logic                   reg_write_in,
  input  wire logic                   reg_read_in,
  output logic      [7:0]             reg_rdata_out,
  input  wire logic                   pwm_trigger_in,
  input  wire logic                   comparator_in,
  input  wire logic                   internal_rc_clock_in,
  input  wire logic                   pin3_digital_fn_in,
  output sac_analog_t                 analog_out,
  output logic                        conversion_done_flag_out
);

  // ----------------------------------------------------------------------
  // decoders
  // ----------------------------------------------------------------------
  // terminal count of the oscillator divider, one less than the ratio
  function automatic logic [5:0] div_last(input logic [2:0] code);
    case (code)
      3'h0:    div_last = 6'h01;
      3'h4:    div_last = 6'h03;
      3'h1:    div_last = 6'h07;
      3'h5:    div_last = 6'h0f;
      3'h2:    div_last = 6'h1f;
      3'h6:    div_last = 6'h3f;
      default: div_last = 6'h01;
    endcase
  endfunction : div_last

  // programmed acquisition length in bit periods
  function automatic logic [4:0] acq_tads(input logic [2:0] code);
    case (code)
      3'h7:    acq_tads = 5'h14;
      3'h6:    acq_tads = 5'h10;
      3'h5:    acq_tads = 5'h0c;
      3'h4:    acq_tads = 5'h08;
      3'h3:    acq_tads = 5'h06;
      3'h2:    acq_tads = 5'h04;
      3'h1:    acq_tads = 5'h02;
      default: acq_tads = 5'h00;
    endcase
  endfunction : acq_tads

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  sac_ctrl0_t      ctrl0_reg;
  sac_pin_config_t pin_reg;
  sac_timing_t     timing_reg;
  sac_state_t      state_reg;
  sac_state_t      state_next;
  logic [7:0]      result_high_reg;
  logic [7:0]      result_low_reg;
  logic            flag_reg;
  logic [7:0]      rdata_reg;
  logic [5:0]      div_reg;
  logic [4:0]      tad_reg;
  logic [2:0]      tcy_reg;
  logic [9:0]      sar_reg;
  logic [9:0]      mask_reg;
  logic            comp_sync_reg;
  logic            rc_meta_reg;
  logic            rc_sync_reg;
  logic            rc_prev_reg;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // the rc oscillator is asynchronous, so it takes two stages; the comparator
  // settles from our own dac code within a cycle, and a two-clock bit period
  // leaves room for one sample stage only
  always_ff @(posedge ref_clk_in) begin
    comp_sync_reg <= comparator_in;
    rc_meta_reg   <= internal_rc_clock_in;
    rc_sync_reg   <= rc_meta_reg;
    rc_prev_reg   <= rc_sync_reg;
  end

  // ----------------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------------
  wire wr_ctrl0  = reg_write_in && (reg_addr_in == `SAC_OFS_CTRL0);
  wire wr_pin    = reg_write_in && (reg_addr_in == `SAC_OFS_PIN_CONFIG);
  wire wr_timing = reg_write_in && (reg_addr_in == `SAC_OFS_TIMING);
  wire wr_high   = reg_write_in && (reg_addr_in == `SAC_OFS_RESULT_HIGH);
  wire wr_low    = reg_write_in && (reg_addr_in == `SAC_OFS_RESULT_LOW);
  wire wr_status = reg_write_in && (reg_addr_in == `SAC_OFS_STATUS);

  wire sac_ctrl0_t wr_ctrl0_val = sac_ctrl0_t'(reg_wdata_in & `SAC_CTRL0_MASK);

  // ----------------------------------------------------------------------
  // bit-period clock
  // ----------------------------------------------------------------------
  wire rc_selected = (timing_reg.conversion_clock_select[1:0] == `SAC_RC_CODE_LOW);
  wire [5:0] div_end = div_last(timing_reg.conversion_clock_select);
  wire rc_tick  = rc_sync_reg && !rc_prev_reg;
  wire div_tick = (div_reg == div_end);
  wire timed    = (state_reg == ST_ACQUIRE) || (state_reg == ST_CONVERT) ||
                  (state_reg == ST_WAIT);
  wire tad_tick = timed && (rc_selected ? rc_tick : div_tick);

  // ----------------------------------------------------------------------
  // start, abort and completion
  // ----------------------------------------------------------------------
  wire [4:0] acq_len  = acq_tads(timing_reg.acquisition_time_select);
  wire pwm_start      = pwm_trigger_in && ctrl0_reg.pwm_trigger_enable;
  wire sw_go_set      = wr_ctrl0 && wr_ctrl0_val.go;
  wire sw_go_clear    = wr_ctrl0 && !wr_ctrl0_val.go;
  wire on_next        = wr_ctrl0 ? wr_ctrl0_val.converter_on : ctrl0_reg.converter_on;
  wire busy           = (state_reg != ST_SAMPLE) && (state_reg != ST_WAIT);
  wire abort          = busy && (sw_go_clear || !on_next);
  wire conv_last      = (state_reg == ST_CONVERT) && tad_tick &&
                        (tad_reg == 5'(`SAC_CONV_TADS - 1));
  wire conv_done      = conv_last && !abort;
  wire tcy_done       = (tcy_reg == 3'(`SAC_TCY_CYCLES - 1));

  // successive approximation: keep or drop the trial bit, then try the next
  wire [9:0] sar_kept = comp_sync_reg ? sar_reg : (sar_reg & ~mask_reg);
  wire [9:0] result   = sar_kept;

  // ----------------------------------------------------------------------
  // result layout
  // ----------------------------------------------------------------------
  wire [7:0] res_high_fmt = timing_reg.result_justify ? {6'h00, result[9:8]}
                                                      : result[9:2];
  wire [7:0] res_low_fmt  = timing_reg.result_justify ? result[7:0]
                                                      : {result[1:0], 6'h00};

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SAMPLE: begin
        if (ctrl0_reg.go && ctrl0_reg.converter_on) begin
          if (rc_selected) begin
            state_next = ST_RC_DELAY;
          end else if (acq_len != 5'h00) begin
            state_next = ST_ACQUIRE;
          end else begin
            state_next = ST_CONVERT;
          end
        end
      end
      ST_RC_DELAY: begin
        if (tcy_done) begin
          state_next = (acq_len != 5'h00) ? ST_ACQUIRE : ST_CONVERT;
        end
      end
      ST_ACQUIRE: begin
        if (tad_tick && (tad_reg == acq_len - 5'h01)) begin
          state_next = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (conv_last) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (tad_tick && (tad_reg == 5'(`SAC_WAIT_TADS - 1))) begin
          state_next = ST_SAMPLE;
        end
      end
      default: state_next = ST_SAMPLE;
    endcase
    if (abort) begin
      state_next = on_next ? ST_WAIT : ST_SAMPLE;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_reg <= ST_SAMPLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // bit-period counting restarts on every change of state
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || (state_next != state_reg)) begin
      div_reg <= 6'h00;
      tad_reg <= 5'h00;
    end else begin
      div_reg <= div_tick ? 6'h00 : div_reg + 6'h01;
      tad_reg <= tad_tick ? tad_reg + 5'h01 : tad_reg;
    end
  end

  // one instruction cycle before an RC-clocked start, room for sleep entry
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || (state_reg != ST_RC_DELAY)) begin
      tcy_reg <= 3'h0;
    end else begin
      tcy_reg <= tcy_reg + 3'h1;
    end
  end

  // ----------------------------------------------------------------------
  // approximation register
  // ----------------------------------------------------------------------
  // the first bit period is setup; bits 9..0 are decided in periods 2..11
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || (state_reg != ST_CONVERT)) begin
      sar_reg  <= 10'h000;
      mask_reg <= 10'h000;
    end else if (tad_tick) begin
      if (tad_reg == 5'h00) begin
        sar_reg  <= 10'h200;
        mask_reg <= 10'h200;
      end else begin
        sar_reg  <= sar_kept | (mask_reg >> 1);
        mask_reg <= mask_reg >> 1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl0_reg  <= sac_ctrl0_t'(`SAC_CTRL0_RESET);
      pin_reg    <= sac_pin_config_t'(`SAC_PIN_RESET);
      timing_reg <= sac_timing_t'(`SAC_TIMING_RESET);
    end else begin
      if (wr_ctrl0) begin
        ctrl0_reg    <= wr_ctrl0_val;
        ctrl0_reg.go <= wr_ctrl0_val.go && wr_ctrl0_val.converter_on;
      end else if (pwm_start && ctrl0_reg.converter_on) begin
        ctrl0_reg.go <= 1'b1;
      end else if (conv_done) begin
        ctrl0_reg.go <= 1'b0;
      end
      if (wr_pin) begin
        pin_reg <= sac_pin_config_t'(reg_wdata_in & `SAC_PIN_MASK);
      end
      if (wr_timing) begin
        timing_reg <= sac_timing_t'(reg_wdata_in & `SAC_TIMING_MASK);
      end
    end
  end

  // ----------------------------------------------------------------------
  // result pair and completion flag
  // ----------------------------------------------------------------------
  // no reset here: the pair keeps whatever it held across any reset
  always_ff @(posedge ref_clk_in) begin
    if (conv_done) begin
      result_high_reg <= res_high_fmt;
      result_low_reg  <= res_low_fmt;
    end else begin
      if (wr_high) begin
        result_high_reg <= reg_wdata_in;
      end
      if (wr_low) begin
        result_low_reg <= reg_wdata_in;
      end
    end
  end

  // a completion in the cycle software clears the flag keeps it set
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      flag_reg <= 1'b0;
    end else if (conv_done) begin
      flag_reg <= 1'b1;
    end else if (wr_status && !reg_wdata_in[`SAC_STATUS_FLAG_BIT]) begin
      flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  wire [7:0] pin_view = {pin_reg[7:4],
                         pin_reg.pin_analog_select[`SAC_PIN3_BIT] && pin3_digital_fn_in,
                         pin_reg.pin_analog_select[2:0]};
  wire [7:0] ctrl0_view = ctrl0_reg & `SAC_CTRL0_MASK;

  wire [7:0] rd_mux =
    (reg_addr_in == `SAC_OFS_CTRL0)       ? ctrl0_view :
    (reg_addr_in == `SAC_OFS_PIN_CONFIG)  ? pin_view :
    (reg_addr_in == `SAC_OFS_TIMING)      ? (timing_reg & `SAC_TIMING_MASK) :
    (reg_addr_in == `SAC_OFS_RESULT_HIGH) ? result_high_reg :
    (reg_addr_in == `SAC_OFS_RESULT_LOW)  ? result_low_reg :
    (reg_addr_in == `SAC_OFS_STATUS)      ? {7'h00, flag_reg} : 8'h00;

  // data stands for the single cycle after the read strobe
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_read_in ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // analog front end controls
  // ----------------------------------------------------------------------
  // the hold capacitor tracks the input only while sampling, in the RC delay or acquiring
  wire sampling = ctrl0_reg.converter_on &&
                  ((state_reg == ST_SAMPLE) || (state_reg == ST_RC_DELAY) ||
                   (state_reg == ST_ACQUIRE));

  always_comb begin
    analog_out.converter_on         = ctrl0_reg.converter_on;
    analog_out.channel_select       = ctrl0_reg.channel_select;
    analog_out.reference_select     = pin_reg.reference_select;
    analog_out.sample_switch_closed = sampling;
    analog_out.dac_code             = sar_reg;
    analog_out.pin_analog           = pin_reg.pin_analog_select;
  end

  assign reg_rdata_out            = rdata_reg;
  assign conversion_done_flag_out = flag_reg;

endmodule : sac_adc_ctrl

`default_nettype wire

//--- sac_adc_ctrl_asserts.sv
// checker for the converter control block, bound to its top ports
`timescale 1ns/1ps
`default_nettype none
`include "sac_cfg.svh"

module sac_adc_ctrl_asserts
  import sac_pkg::*;
(
  input wire logic                   ref_clk_in,
  input wire logic                   rst_in,
  input wire logic [`SAC_ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0]             reg_wdata_in,
  input wire logic                   reg_write_in,
  input wire logic                   reg_read_in,
  input wire logic [7:0]             reg_rdata_out,
  input wire logic                   pwm_trigger_in,
  input wire logic                   comparator_in,
  input wire logic                   internal_rc_clock_in,
  input wire logic                   pin3_digital_fn_in,
  input wire sac_analog_t            analog_out,
  input wire logic                   conversion_done_flag_out
);
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic [7:0] open_cnt_reg;
  logic [7:0] open_cnt_next;
  wire  [7:0] keep_w = (reg_addr_in == 3'h0) ? 8'h8f : (reg_addr_in == 3'h1) ? 8'h1f : 8'hbf;
  // saturate so a long divide-by-64 conversion cannot wrap the count
  assign open_cnt_next = analog_out.sample_switch_closed ? 8'h00 :
                         (open_cnt_reg == 8'hff) ? open_cnt_reg : open_cnt_reg + 8'h01;
  always_ff @(posedge ref_clk_in) open_cnt_reg <= rst_in ? 8'h00 : open_cnt_next;

  sequence s_wait_open;
    !analog_out.sample_switch_closed [*4];
  endsequence

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  a_reset_state: assert property ($fell(rst_in) |-> !analog_out.converter_on
    && !conversion_done_flag_out && analog_out.pin_analog == 4'hf) else $error("bad reset");
  a_unmapped_read: assert property (reg_read_in && reg_addr_in > 3'h5 |=>
    reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  a_unused_zero: assert property (reg_read_in && reg_addr_in < 3'h3 |=>
    (reg_rdata_out & ~$past(keep_w)) == 8'h00) else $error("unused bit set");
  a_pin3_masked: assert property (reg_read_in && reg_addr_in == 3'h1 &&
    !pin3_digital_fn_in |=> !reg_rdata_out[3]) else $error("pin3 bit not masked");
  a_ctrl_write: assert property (reg_write_in && reg_addr_in == 3'h0 |=>
    analog_out.converter_on == $past(reg_wdata_in[0]) &&
    analog_out.channel_select == $past(reg_wdata_in[3:2])) else $error("ctrl write lost");
  a_pin_write: assert property (reg_write_in && reg_addr_in == 3'h1 |=>
    analog_out.reference_select == $past(reg_wdata_in[4]) &&
    analog_out.pin_analog == $past(reg_wdata_in[3:0])) else $error("pin write lost");
  a_flag_sticky: assert property (conversion_done_flag_out &&
    !(reg_write_in && reg_addr_in == 3'h5) |=> conversion_done_flag_out) else $error("flag lost");
  a_wait_after: assert property ($rose(conversion_done_flag_out) |-> s_wait_open)
    else $error("sampling resumed too early");
  a_conv_length: assert property ($rose(conversion_done_flag_out) |->
    open_cnt_reg >= 8'h16) else $error("conversion too short");
endmodule : sac_adc_ctrl_asserts
`default_nettype wire

//--- sac_analog_model.sv
// behavioural model of the analog inputs and the internal rc oscillator
`timescale 1ns/1ps
`default_nettype none

module sac_analog_model
  import sac_pkg::*;
(
  input  wire logic            ref_clk_in,
  input  wire sac_analog_t     analog_in,
  input  wire logic [3:0][9:0] levels_in,
  output logic                 comparator_out,
  output logic                 rc_clock_out
);
  logic [9:0] held_reg = 10'h000;
  always @(posedge ref_clk_in) begin
    if (analog_in.converter_on && analog_in.sample_switch_closed) begin
      held_reg <= levels_in[analog_in.channel_select];
    end
  end
  // input sits half a step above its code, so either comparator reading gives that code
  assign comparator_out = {held_reg, 1'b1} > {analog_in.dac_code, 1'b0};
  // free running, about 5.75 system clocks a period, unrelated in phase
  initial begin
    rc_clock_out = 1'b0;
    #3;
    forever #23 rc_clock_out = ~rc_clock_out;
  end
endmodule : sac_analog_model
`default_nettype wire

//--- test_sac_adc_ctrl.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module test_sac_adc_ctrl
  import sac_pkg::*;
;
  typedef struct packed {logic [2:0] acq; logic [2:0] cks; logic [1:0] ch; logic just;} sac_row_t;
  logic            ref_clk_in = 1'b0;
  logic            rst_in = 1'b1;
  logic [2:0]      reg_addr_in = 3'h0;
  logic [7:0]      reg_wdata_in = 8'h00;
  logic            reg_write_in = 1'b0;
  logic            reg_read_in = 1'b0;
  logic            pwm_trigger_in = 1'b0;
  logic            pin3_digital_fn_in = 1'b1;
  logic [7:0]      reg_rdata_out;
  logic            comparator_in;
  logic            internal_rc_clock_in;
  logic            conversion_done_flag_out;
  sac_analog_t     analog_out;
  logic [3:0][9:0] levels = {10'h001, 10'h3ff, 10'h13c, 10'h2a5};
  int              acq_tads [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int              clk_div [8] = '{2, 8, 32, 0, 4, 16, 64, 0};
  int              n_mismatch = 0;
  int              num_checks = 0;
  // every divider code, codes 0 and 4 twice; every acquisition code once
  sac_row_t rows [8] = '{'{3'h0, 3'h0, 2'h0, 1'b1}, '{3'h1, 3'h4, 2'h1, 1'b0},
    '{3'h2, 3'h1, 2'h2, 1'b1}, '{3'h3, 3'h5, 2'h3, 1'b0}, '{3'h4, 3'h2, 2'h0, 1'b0},
    '{3'h5, 3'h6, 2'h1, 1'b1}, '{3'h6, 3'h0, 2'h2, 1'b0}, '{3'h7, 3'h4, 2'h3, 1'b1}};

  sac_adc_ctrl i_dut (.ref_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
    .reg_read_in, .reg_rdata_out, .pwm_trigger_in, .comparator_in, .internal_rc_clock_in,
    .pin3_digital_fn_in, .analog_out, .conversion_done_flag_out);
  sac_analog_model i_model (.ref_clk_in, .analog_in(analog_out), .levels_in(levels),
    .comparator_out(comparator_in), .rc_clock_out(internal_rc_clock_in));

  // ----------------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_write_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] ex);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_read_in <= 1'b0;
    #1;
    `CHK($sformatf("reg %0h", a), ex, reg_rdata_out)
  endtask : rd
  task automatic pulse();
    @(posedge ref_clk_in);
    pwm_trigger_in <= 1'b1;
    @(posedge ref_clk_in);
    pwm_trigger_in <= 1'b0;
  endtask : pulse
  // counts cycles from the go write to the switch opening and to the done flag
  task automatic conv(input logic [7:0] c, output int n, output int n_open);
    wr(3'h0, c & 8'hfd);
    repeat (200) @(posedge ref_clk_in);
    wr(3'h0, c);
    n = 1;
    n_open = 0;
    #1;
    while (!conversion_done_flag_out && n < 3000) begin
      @(posedge ref_clk_in);
      #1;
      n++;
      if (!analog_out.sample_switch_closed && n_open == 0) n_open = n;
    end
  endtask : conv
  task automatic test_done();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------------------------------------
  initial begin
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    repeat (30000) @(posedge ref_clk_in);
    n_mismatch++;
    test_done();
  end
  initial begin
    sac_row_t   r;
    logic [9:0] lv;
    int         n;
    int         n_open;
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      lv = levels[r.ch];
      wr(3'h2, {r.just, 1'b0, r.acq, r.cks});
      conv({4'h0, r.ch, 2'h3}, n, n_open);
      `CHK("acq span", 2 + acq_tads[r.acq] * clk_div[r.cks], n_open)
      `CHK("conv span", 2 + (acq_tads[r.acq] + 11) * clk_div[r.cks], n)
      rd(3'h3, r.just ? {6'h00, lv[9:8]} : lv[9:2]);
      rd(3'h4, r.just ? lv[7:0] : {lv[1:0], 6'h00});
      rd(3'h0, {4'h0, r.ch, 2'h1});
      rd(3'h5, 8'h01);
      wr(3'h5, 8'h00);
    end
    // sleep clock: start held back one instruction cycle
    wr(3'h2, 8'h83);
    conv(8'h0f, n, n_open);
    `CHK("rc delay", 1'b1, n_open >= 6)
    rd(3'h4, 8'h01);
    wr(3'h5, 8'h00);
    // busy view, unused bits, abort keeps old result
    wr(3'h2, 8'hff);
    rd(3'h2, 8'hbf);
    wr(3'h0, 8'hff);
    rd(3'h0, 8'h8f);
    wr(3'h0, 8'h0d);
    repeat (400) @(posedge ref_clk_in);
    #1;
    `CHK("abort flag", 1'b0, conversion_done_flag_out)
    `CHK("resume", 1'b1, analog_out.sample_switch_closed)
    rd(3'h4, 8'h01);
    wr(3'h1, 8'hff);
    rd(3'h1, 8'h1f);
    pin3_digital_fn_in <= 1'b0;
    rd(3'h1, 8'h17);
    pin3_digital_fn_in <= 1'b1;
    wr(3'h7, 8'hff);
    rd(3'h6, 8'h00);
    wr(3'h3, 8'h5a);
    rd(3'h3, 8'h5a);
    // trigger ignored while disabled, then honoured
    wr(3'h2, 8'h80);
    wr(3'h0, 8'h05);
    pulse();
    rd(3'h0, 8'h05);
    wr(3'h0, 8'h85);
    pulse();
    rd(3'h0, 8'h87);
    for (n = 0; n < 200 && !conversion_done_flag_out; n++) @(posedge ref_clk_in);
    rd(3'h3, 8'h01);
    wr(3'h5, 8'h00);
    // reset in mid conversion
    wr(3'h0, 8'h07);
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(3'h0, 8'h00);
    rd(3'h1, 8'h0f);
    rd(3'h2, 8'h00);
    rd(3'h4, 8'h3c);
    repeat (100) @(posedge ref_clk_in);
    #1;
    `CHK("reset abort", 1'b0, conversion_done_flag_out)
    test_done();
  end
endmodule : test_sac_adc_ctrl

bind sac_adc_ctrl sac_adc_ctrl_asserts i_chk (.ref_clk_in, .rst_in, .reg_addr_in,
  .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .pwm_trigger_in,
  .comparator_in, .internal_rc_clock_in, .pin3_digital_fn_in, .analog_out,
  .conversion_done_flag_out);
`default_nettype wire
